// >>> bench/cfm_regs_tb_top.sv
// Purpose: self-checking bench for the clock/fifo/misc config bank
// Assumes: host strobes driven on clk_sys rising edge, one cycle each
// Notes: register model in the bench, expectations from field rules
`timescale 1ns/1ps

module cfm_regs_tb_top;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	cfm_pkg::cfm_io_req_t io_req = '0;
	logic [7:0] io_rdata;
	logic io_rvalid, io_hit, host_nowait, host_hold;
	logic [4:0] disp_fifo_level = 5'h00;
	logic [3:0] attr_fifo_thresh;
	logic pixel_clock_set_sel = 1'b0;
	logic [7:0] pix_num_a = 8'h00;
	logic [7:0] pix_num_b = 8'h00;
	logic mode_16col = 1'b0;
	cfm_pkg::cfm_synth_t pix_synth, mem_synth;
	cfm_pkg::cfm_clk_ctl_t clk_ctl;
	cfm_pkg::cfm_misc_t misc_ctl;
	logic [7:0] mdl [8];
	int err_count = 0;
	int n_compared = 0;

	// 25 MHz system clock
	always #20 clk_sys = ~clk_sys;

	cfm_regs #(.LVL_W(5)) i_dut (.clk_sys(clk_sys), .rstn(rstn), .io_req(io_req),
		.io_rdata(io_rdata), .io_rvalid(io_rvalid), .io_hit(io_hit),
		.disp_fifo_level(disp_fifo_level), .host_nowait(host_nowait),
		.host_hold(host_hold), .attr_fifo_thresh(attr_fifo_thresh),
		.pixel_clock_set_sel(pixel_clock_set_sel), .pix_num_a(pix_num_a),
		.pix_num_b(pix_num_b), .mode_16col(mode_16col), .pix_synth(pix_synth),
		.mem_synth(mem_synth), .clk_ctl(clk_ctl), .misc_ctl(misc_ctl));

	// ----------------------------------------------------------------
	// compare, verdict and expectation helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic test_done();
		$display("compares %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done

	// multiplier and divisor words of one synthesizer
	function automatic logic [19:0] synth_exp(input logic [7:0] num, input logic [7:0] dp);
		logic [9:0] m;
		logic [9:0] d;
		m = ({3'h0, num[6:0]} + 10'h001) * (dp[0] ? 10'h004 : 10'h002);
		d = ({3'h0, dp[7:1]} + 10'h001) * (num[7] ? 10'h004 : 10'h002);
		return {m, d};
	endfunction : synth_exp

	// ----------------------------------------------------------------
	// host i/o tasks
	// ----------------------------------------------------------------
	task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		io_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		io_req <= '0;
	endtask : io_wr

	task automatic io_rd(input logic [15:0] a, input logic ev, input logic [7:0] ed);
		@(posedge clk_sys);
		io_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys);
		io_req <= '0;
		#1;
		chk("io_rvalid", {19'h0, ev}, {19'h0, io_rvalid});
		chk("io_hit", {19'h0, ev}, {19'h0, io_hit});
		if (ev) chk("io_rdata", {12'h0, ed}, {12'h0, io_rdata});
	endtask : io_rd

	task automatic reg_wr(input int s, input logic [7:0] d);
		io_wr(16'h03C4, 8'hC5 + 8'(s));
		io_wr(16'h03C5, d);
		mdl[s] = (s == 3) ? (d & 8'h07) : d;
	endtask : reg_wr

	task automatic read_all();
		for (int s = 0; s < 8; s++) begin
			io_wr(16'h03C4, 8'hC5 + 8'(s));
			io_rd(16'h03C5, 1'b1, mdl[s]);
		end
	endtask : read_all

	task automatic do_reset();
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		mdl = '{8'h83, 8'h00, 8'h00, 8'h00, 8'hA1, 8'h00, 8'h00, 8'h00};
	endtask : do_reset

	// decoded outputs against the model, two edges after the last change
	task automatic check_all();
		logic [7:0] ct;
		logic [7:0] mc;
		logic [1:0] obs;
		ct = mdl[6];
		mc = mdl[7];
		obs = ct[1] ? 2'h2 : {1'b0, ct[0]};
		repeat (2) @(posedge clk_sys);
		#1;
		chk("pix_synth", pixel_clock_set_sel ? synth_exp(pix_num_b, mdl[1]) :
			synth_exp(pix_num_a, mdl[0]), pix_synth);
		chk("mem_synth", synth_exp(mdl[4], mdl[5]), mem_synth);
		chk("attr_thresh", {16'h0, 1'b0, mdl[3][2:0]} + 20'h1, {16'h0, attr_fifo_thresh});
		chk("clk_ctl", {12'h0, obs, ct[3:2], ct[4], ct[5], ct[6], ct[7]},
			{12'h0, clk_ctl});
		chk("misc_ctl", {11'h0, mc[0], mc[1], mc[1], 1'b0, mc[3], mc[5:4],
			mode_16col & mc[6], mc[7]}, {11'h0, misc_ctl});
	endtask : check_all

	// sweep every fifo level against the two thresholds
	task automatic sweep_levels();
		logic [5:0] hi;
		logic [5:0] lo;
		hi = {2'h0, mdl[2][3:0]} + 6'h04;
		lo = {2'h0, mdl[2][7:4]} + 6'h03;
		for (int lv = 0; lv < 32; lv++) begin
			@(posedge clk_sys);
			disp_fifo_level <= 5'(lv);
			@(posedge clk_sys);
			#1;
			chk("host_nowait", {19'h0, 6'(lv) > hi}, {19'h0, host_nowait});
			chk("host_hold", {19'h0, 6'(lv) < lo}, {19'h0, host_hold});
		end
	endtask : sweep_levels

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	initial begin
		#(40 * 30000);
		err_count++;
		test_done();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] d;
		void'($urandom(49174));
		do_reset();
		check_all();
		read_all();
		sweep_levels();
		// corner rounds all ones, all zeros and alternate bits, then random rounds
		for (int r = 0; r < 16; r++) begin
			@(posedge clk_sys);
			pix_num_a <= 8'($urandom);
			pix_num_b <= 8'($urandom);
			pixel_clock_set_sel <= r[0];
			mode_16col <= r[1];
			for (int s = 0; s < 8; s++) begin
				d = (r == 0) ? 8'hFF : (r == 1) ? 8'h00 : (r == 2) ? 8'h55 : 8'($urandom);
				reg_wr(s, d);
			end
			#1;
			chk("tg_reset", {19'h0, d[2]}, {19'h0, misc_ctl.tg_reset});
			check_all();
			chk("tg_reset_end", 20'h0, {19'h0, misc_ctl.tg_reset});
			read_all();
			if (r < 4) sweep_levels();
		end
		// indexes outside the bank are ignored
		io_wr(16'h03C4, 8'hC4);
		io_wr(16'h03C5, 8'h5A);
		io_rd(16'h03C5, 1'b0, 8'h00);
		io_wr(16'h03C4, 8'hCD);
		io_wr(16'h03C5, 8'hA5);
		io_rd(16'h03C5, 1'b0, 8'h00);
		io_rd(16'h03C4, 1'b1, 8'hCD);
		// back-to-back data write then read of one register
		io_wr(16'h03C4, 8'hC7);
		@(posedge clk_sys);
		io_req <= '{wr: 1'b1, rd: 1'b0, addr: 16'h03C5, wdata: 8'h3C};
		@(posedge clk_sys);
		io_req <= '{wr: 1'b0, rd: 1'b1, addr: 16'h03C5, wdata: 8'h00};
		@(posedge clk_sys);
		io_req <= '0;
		mdl[2] = 8'h3C;
		#1;
		chk("b2b_rvalid", 20'h1, {19'h0, io_rvalid});
		chk("b2b_rdata", {12'h0, mdl[2]}, {12'h0, io_rdata});
		read_all();
		// reset in mid-run restores defaults
		do_reset();
		check_all();
		read_all();
		test_done();
	end
endmodule : cfm_regs_tb_top

// >>> common/cfm_pkg.sv
// Purpose: shared constants and carrier types for the clock/fifo/misc config bank
// Assumes: 8-bit host I/O port access, one system clock
// Notes: register slots are numbered from the first extended index upward
package cfm_pkg;

	// ----------------------------------------------------------------
	// host i/o ports
	// ----------------------------------------------------------------
	localparam logic [15:0] CFM_PORT_INDEX = 16'h03C4;
	localparam logic [15:0] CFM_PORT_DATA = 16'h03C5;

	// ----------------------------------------------------------------
	// extended register indexes
	// ----------------------------------------------------------------
	localparam logic [7:0] CFM_IDX_PIXA_DP = 8'hC5;
	localparam logic [7:0] CFM_IDX_PIXB_DP = 8'hC6;
	localparam logic [7:0] CFM_IDX_FIFO_THR = 8'hC7;
	localparam logic [7:0] CFM_IDX_ATTR_THR = 8'hC8;
	localparam logic [7:0] CFM_IDX_MEM_NUM = 8'hC9;
	localparam logic [7:0] CFM_IDX_MEM_DP = 8'hCA;
	localparam logic [7:0] CFM_IDX_CLK_TEST = 8'hCB;
	localparam logic [7:0] CFM_IDX_MISC = 8'hCC;
	localparam int CFM_NREG = 8;

	// slot numbers inside the bank
	localparam logic [2:0] CFM_SLOT_PIXA = 3'h0;
	localparam logic [2:0] CFM_SLOT_PIXB = 3'h1;
	localparam logic [2:0] CFM_SLOT_FIFO = 3'h2;
	localparam logic [2:0] CFM_SLOT_ATTR = 3'h3;
	localparam logic [2:0] CFM_SLOT_MNUM = 3'h4;
	localparam logic [2:0] CFM_SLOT_MDP = 3'h5;
	localparam logic [2:0] CFM_SLOT_CTST = 3'h6;
	localparam logic [2:0] CFM_SLOT_MISC = 3'h7;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CFM_RST_PIXA_DP = 8'h83;
	localparam logic [7:0] CFM_RST_PIXB_DP = 8'h00;
	localparam logic [7:0] CFM_RST_FIFO_THR = 8'h00;
	localparam logic [7:0] CFM_RST_ATTR_THR = 8'h00;
	localparam logic [7:0] CFM_RST_MEM_NUM = 8'hA1;
	localparam logic [7:0] CFM_RST_MEM_DP = 8'h00;
	localparam logic [7:0] CFM_RST_CLK_TEST = 8'h00;
	localparam logic [7:0] CFM_RST_MISC = 8'h00;
	localparam logic [7:0][7:0] CFM_RST_VEC = {CFM_RST_MISC, CFM_RST_CLK_TEST,
		CFM_RST_MEM_DP, CFM_RST_MEM_NUM, CFM_RST_ATTR_THR, CFM_RST_FIFO_THR,
		CFM_RST_PIXB_DP, CFM_RST_PIXA_DP};

	// writable bits per slot; attribute threshold keeps only its low field
	localparam logic [7:0] CFM_WMASK_FULL = 8'hFF;
	localparam logic [7:0] CFM_WMASK_ATTR = 8'h07;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CFM_DP_POST = 0; // post-scaler bit
	localparam int CFM_DP_DEN_LO = 1; // denominator bits 7:1
	localparam int CFM_NUM_PREDIV = 7; // numerator pre-divider bit
	localparam int CFM_THR_HI_LO = 0; // display fifo high, bits 3:0
	localparam int CFM_THR_LO_LO = 4; // display fifo low, bits 7:4
	localparam int CFM_CT_OBS_LO = 0; // observation select 1:0
	localparam int CFM_CT_SRC_LO = 2; // pixel clock source 3:2
	localparam int CFM_CT_TVHALF = 4;
	localparam int CFM_CT_MEM_PD = 5;
	localparam int CFM_CT_PIX_PD = 6;
	localparam int CFM_CT_OSC_PD = 7;
	localparam int CFM_MC_SENSE_PD = 0;
	localparam int CFM_MC_DAC_PD = 1;
	localparam int CFM_MC_TG_RST = 2;
	localparam int CFM_MC_PAL_PD = 3;
	localparam int CFM_MC_WIDTH_LO = 4; // host width 5:4
	localparam int CFM_MC_BUS16 = 6;
	localparam int CFM_MC_BYPASS = 7;

	// ----------------------------------------------------------------
	// threshold offsets and synthesizer reference
	// ----------------------------------------------------------------
	localparam logic [4:0] CFM_HI_THR_BIAS = 5'h04;
	localparam logic [4:0] CFM_LO_THR_BIAS = 5'h03;
	localparam logic [3:0] CFM_ATTR_THR_BIAS = 4'h1;
	localparam int CFM_OSC_REF_KHZ = 14318;

	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {CFM_OBS_OTHER, CFM_OBS_MEMCLK, CFM_OBS_PIXCLK} cfm_obs_t;
	typedef enum logic [1:0] {CFM_SRC_PIXSYN, CFM_SRC_MEM_DIV2, CFM_SRC_PIX_DIV2,
		CFM_SRC_MEMSYN} cfm_src_t;
	typedef enum logic [1:0] {CFM_W8, CFM_W16, CFM_W32, CFM_W32_16} cfm_width_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} cfm_io_req_t;

	typedef struct packed {
		logic [9:0] mult; // (n+1)*(2p+2)
		logic [9:0] div; // (d+1)*prediv
	} cfm_synth_t;

	typedef struct packed {
		cfm_obs_t obs_sel;
		cfm_src_t pix_src;
		logic tv_half;
		logic mem_pd;
		logic pix_pd;
		logic osc_pd;
	} cfm_clk_ctl_t;

	typedef struct packed {
		logic sense_pd;
		logic dac_pd;
		logic refresh_stop;
		logic tg_reset;
		logic pal_pd;
		cfm_width_t host_width;
		logic bus16;
		logic pal_bypass;
	} cfm_misc_t;

endpackage : cfm_pkg

// >>> hw/cfm_regs.sv
// Purpose: extended sequencer config bank for clocks, fifo thresholds and misc control
// Assumes: host i/o strobes synchronous to clk_sys, one cycle each
// Notes: all outputs are fields of the registered state
//
// Notes on behaviour
// - registers read/written via data port after index
// - pixel set a divisor register resets to 83
// - set a: bit0 post-scaler, bits7:1 denominator
// - set b uses the same layout
// - fifo high field bits3:0, zero means four
// - fifo low field bits7:4, zero means three
// - above high threshold host runs without waits
// - below low threshold only display fetches granted
// - attribute threshold bits2:0, zero means one
// - memory numerator resets a1, prediv in bit7
// - memory divisor: bit0 post, bits7:1 denominator
// - bits1:0 pick observation pin clock source
// - bits3:2 pick the pixel clock source
// - bit4 halves video clock for tv sync
// - bits5-7 power down synths and oscillator
// - misc bit0 powers down monitor sense
// - misc bit1 powers down dac, stops refresh
// - writing misc bit2 resets timing generator
// - misc bit3 powers down the palette
// - misc bits5:4 select host data width
// - misc bit6 widens 16-colour host accesses
// - misc bit7 bypasses palette lookup memory
// - synth frequency ref*(n+1)*(2p+2)/(d+1)
// - prediv bit: zero divides two, one four
// - pixel select low uses set a, high b
`timescale 1ns/1ps

module cfm_regs #(
	parameter int LVL_W = 5
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// host i/o port
	input cfm_pkg::cfm_io_req_t io_req,
	output logic [7:0] io_rdata,
	output logic io_rvalid,
	output logic io_hit,
	// display fifo arbitration
	input wire logic [LVL_W-1:0] disp_fifo_level,
	output logic host_nowait,
	output logic host_hold,
	output logic [3:0] attr_fifo_thresh,
	// pixel clock set selection and numerators held elsewhere
	input wire logic pixel_clock_set_sel,
	input wire logic [7:0] pix_num_a,
	input wire logic [7:0] pix_num_b,
	input wire logic mode_16col,
	// synthesizer programming
	output cfm_pkg::cfm_synth_t pix_synth,
	output cfm_pkg::cfm_synth_t mem_synth,
	// clock test and misc control
	output cfm_pkg::cfm_clk_ctl_t clk_ctl,
	output cfm_pkg::cfm_misc_t misc_ctl
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] index;
		logic [7:0][7:0] regs;
		logic [7:0] rdata;
		logic rvalid;
		logic hit;
		logic nowait;
		logic hold;
		logic [3:0] attr_thr;
		cfm_pkg::cfm_synth_t pix;
		cfm_pkg::cfm_synth_t mem;
		cfm_pkg::cfm_clk_ctl_t clk;
		cfm_pkg::cfm_misc_t misc;
	} cfm_state_t;

	cfm_state_t s_r;
	cfm_state_t s_nxt;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	logic idx_in_bank;
	logic [7:0] idx_off;
	logic [2:0] slot;
	logic data_wr;
	logic data_rd;
	logic [7:0] wmask;
	logic [7:0] pix_dp;
	logic [7:0] pix_num;
	logic [4:0] hi_thr;
	logic [4:0] lo_thr;
	logic [LVL_W-1:0] lvl_hi;
	logic [LVL_W-1:0] lvl_lo;

	// bank membership of the current index
	assign idx_in_bank = (s_r.index >= cfm_pkg::CFM_IDX_PIXA_DP) &&
		(s_r.index <= cfm_pkg::CFM_IDX_MISC);
	assign idx_off = s_r.index - cfm_pkg::CFM_IDX_PIXA_DP;
	assign slot = idx_off[2:0];
	assign data_wr = io_req.wr && (io_req.addr == cfm_pkg::CFM_PORT_DATA) && idx_in_bank;
	assign data_rd = io_req.rd && (io_req.addr == cfm_pkg::CFM_PORT_DATA) && idx_in_bank;
	assign wmask = (slot == cfm_pkg::CFM_SLOT_ATTR) ? cfm_pkg::CFM_WMASK_ATTR :
		cfm_pkg::CFM_WMASK_FULL;

	// active pixel register set
	assign pix_dp = pixel_clock_set_sel ? s_r.regs[cfm_pkg::CFM_SLOT_PIXB] :
		s_r.regs[cfm_pkg::CFM_SLOT_PIXA];
	assign pix_num = pixel_clock_set_sel ? pix_num_b : pix_num_a;

	// actual display fifo thresholds
	assign hi_thr = {1'b0, s_r.regs[cfm_pkg::CFM_SLOT_FIFO][cfm_pkg::CFM_THR_HI_LO +: 4]} +
		cfm_pkg::CFM_HI_THR_BIAS;
	assign lo_thr = {1'b0, s_r.regs[cfm_pkg::CFM_SLOT_FIFO][cfm_pkg::CFM_THR_LO_LO +: 4]} +
		cfm_pkg::CFM_LO_THR_BIAS;
	assign lvl_hi = LVL_W'(hi_thr);
	assign lvl_lo = LVL_W'(lo_thr);

	// ----------------------------------------------------------------
	// synthesizer relation
	// ----------------------------------------------------------------
	// numerator term (n+1)*(2p+2): post-scaler picks shift by one or two
	function automatic logic [9:0] cfm_mult(input logic [7:0] num, input logic [7:0] dp);
		logic [9:0] n1;
		n1 = {3'h0, num[6:0]} + 10'h001;
		cfm_mult = dp[cfm_pkg::CFM_DP_POST] ? (n1 << 2) : (n1 << 1);
	endfunction : cfm_mult

	// denominator term (d+1) times the oscillator pre-divider of two or four
	function automatic logic [9:0] cfm_div(input logic [7:0] num, input logic [7:0] dp);
		logic [9:0] d1;
		d1 = {3'h0, dp[7:cfm_pkg::CFM_DP_DEN_LO]} + 10'h001;
		cfm_div = num[cfm_pkg::CFM_NUM_PREDIV] ? (d1 << 2) : (d1 << 1);
	endfunction : cfm_div

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.rvalid = 1'b0;
		s_nxt.misc.tg_reset = 1'b0;
		// index port
		if (io_req.wr && (io_req.addr == cfm_pkg::CFM_PORT_INDEX)) begin
			s_nxt.index = io_req.wdata;
		end
		// data port write; reserved bits stay zero
		if (data_wr) begin
			s_nxt.regs[slot] = (s_r.regs[slot] & ~wmask) | (io_req.wdata & wmask);
			if ((slot == cfm_pkg::CFM_SLOT_MISC) && io_req.wdata[cfm_pkg::CFM_MC_TG_RST]) begin
				s_nxt.misc.tg_reset = 1'b1;
			end
		end
		// reads answer next cycle; index port readable too
		s_nxt.hit = 1'b0;
		if (data_rd) begin
			s_nxt.rdata = s_r.regs[slot];
			s_nxt.rvalid = 1'b1;
			s_nxt.hit = 1'b1;
		end else if (io_req.rd && (io_req.addr == cfm_pkg::CFM_PORT_INDEX)) begin
			s_nxt.rdata = s_r.index;
			s_nxt.rvalid = 1'b1;
			s_nxt.hit = 1'b1;
		end
		// arbitration against display fifo fill
		s_nxt.nowait = disp_fifo_level > lvl_hi;
		s_nxt.hold = disp_fifo_level < lvl_lo;
		s_nxt.attr_thr = {1'b0, s_r.regs[cfm_pkg::CFM_SLOT_ATTR][2:0]} +
			cfm_pkg::CFM_ATTR_THR_BIAS;
		// synthesizer programming words
		s_nxt.pix.mult = cfm_mult(pix_num, pix_dp);
		s_nxt.pix.div = cfm_div(pix_num, pix_dp);
		s_nxt.mem.mult = cfm_mult(s_r.regs[cfm_pkg::CFM_SLOT_MNUM],
			s_r.regs[cfm_pkg::CFM_SLOT_MDP]);
		s_nxt.mem.div = cfm_div(s_r.regs[cfm_pkg::CFM_SLOT_MNUM],
			s_r.regs[cfm_pkg::CFM_SLOT_MDP]);
		// clock test decode
		if (s_r.regs[cfm_pkg::CFM_SLOT_CTST][cfm_pkg::CFM_CT_OBS_LO + 1]) begin
			s_nxt.clk.obs_sel = cfm_pkg::CFM_OBS_PIXCLK;
		end else if (s_r.regs[cfm_pkg::CFM_SLOT_CTST][cfm_pkg::CFM_CT_OBS_LO]) begin
			s_nxt.clk.obs_sel = cfm_pkg::CFM_OBS_MEMCLK;
		end else begin
			s_nxt.clk.obs_sel = cfm_pkg::CFM_OBS_OTHER;
		end
		s_nxt.clk.pix_src = cfm_pkg::cfm_src_t'(
			s_r.regs[cfm_pkg::CFM_SLOT_CTST][cfm_pkg::CFM_CT_SRC_LO +: 2]);
		s_nxt.clk.tv_half = s_r.regs[cfm_pkg::CFM_SLOT_CTST][cfm_pkg::CFM_CT_TVHALF];
		s_nxt.clk.mem_pd = s_r.regs[cfm_pkg::CFM_SLOT_CTST][cfm_pkg::CFM_CT_MEM_PD];
		s_nxt.clk.pix_pd = s_r.regs[cfm_pkg::CFM_SLOT_CTST][cfm_pkg::CFM_CT_PIX_PD];
		s_nxt.clk.osc_pd = s_r.regs[cfm_pkg::CFM_SLOT_CTST][cfm_pkg::CFM_CT_OSC_PD];
		// misc control decode
		s_nxt.misc.sense_pd = s_r.regs[cfm_pkg::CFM_SLOT_MISC][cfm_pkg::CFM_MC_SENSE_PD];
		s_nxt.misc.dac_pd = s_r.regs[cfm_pkg::CFM_SLOT_MISC][cfm_pkg::CFM_MC_DAC_PD];
		s_nxt.misc.refresh_stop = s_r.regs[cfm_pkg::CFM_SLOT_MISC][cfm_pkg::CFM_MC_DAC_PD];
		s_nxt.misc.pal_pd = s_r.regs[cfm_pkg::CFM_SLOT_MISC][cfm_pkg::CFM_MC_PAL_PD];
		s_nxt.misc.host_width = cfm_pkg::cfm_width_t'(
			s_r.regs[cfm_pkg::CFM_SLOT_MISC][cfm_pkg::CFM_MC_WIDTH_LO +: 2]);
		s_nxt.misc.bus16 = mode_16col &&
			s_r.regs[cfm_pkg::CFM_SLOT_MISC][cfm_pkg::CFM_MC_BUS16];
		s_nxt.misc.pal_bypass = s_r.regs[cfm_pkg::CFM_SLOT_MISC][cfm_pkg::CFM_MC_BYPASS];
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s_r <= '0;
			s_r.regs <= cfm_pkg::CFM_RST_VEC;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from state
	assign io_rdata = s_r.rdata;
	assign io_rvalid = s_r.rvalid;
	assign io_hit = s_r.hit;
	assign host_nowait = s_r.nowait;
	assign host_hold = s_r.hold;
	assign attr_fifo_thresh = s_r.attr_thr;
	assign pix_synth = s_r.pix;
	assign mem_synth = s_r.mem;
	assign clk_ctl = s_r.clk;
	assign misc_ctl = s_r.misc;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// register views used by the checks
	logic [7:0] ct_reg;
	logic [7:0] mc_reg;
	logic [7:0] fifo_reg;
	logic idx_out;
	logic data_port;
	assign ct_reg = s_r.regs[cfm_pkg::CFM_SLOT_CTST];
	assign mc_reg = s_r.regs[cfm_pkg::CFM_SLOT_MISC];
	assign fifo_reg = s_r.regs[cfm_pkg::CFM_SLOT_FIFO];
	assign idx_out = (s_r.index < cfm_pkg::CFM_IDX_PIXA_DP) ||
		(s_r.index > cfm_pkg::CFM_IDX_MISC);
	assign data_port = io_req.addr == cfm_pkg::CFM_PORT_DATA;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// reset values and host port
	reset_values_a: assert property (@(posedge clk_sys) disable iff (1'b0)
		!rstn |=> (s_r.regs[cfm_pkg::CFM_SLOT_PIXA] == 8'h83) &&
		(s_r.regs[cfm_pkg::CFM_SLOT_MNUM] == 8'hA1))
		else $error("reset values wrong");
	write_read_a: assert property (data_wr && (slot != cfm_pkg::CFM_SLOT_ATTR) ##1
		(io_req.rd && io_req.addr == cfm_pkg::CFM_PORT_DATA && !io_req.wr) |=>
		io_rvalid && (io_rdata == $past(io_req.wdata, 2)))
		else $error("data port readback mismatch");
	read_answer_a: assert property (data_rd |=> io_rvalid && io_hit)
		else $error("bank read not answered");
	read_refused_a: assert property (io_req.rd && data_port && idx_out |=> !io_hit)
		else $error("read outside bank answered");
	write_refused_a: assert property (io_req.wr && data_port && idx_out |=>
		$stable(s_r.regs))
		else $error("write outside bank landed");
	index_wr_a: assert property (io_req.wr && (io_req.addr == cfm_pkg::CFM_PORT_INDEX) |=>
		s_r.index == $past(io_req.wdata))
		else $error("index port write lost");
	index_rd_a: assert property (io_req.rd && (io_req.addr == cfm_pkg::CFM_PORT_INDEX) |=>
		io_hit && (io_rdata == $past(s_r.index)))
		else $error("index port read wrong");
	rvalid_pulse_a: assert property (!io_req.rd |=> !io_rvalid && !io_hit)
		else $error("read answer without request");
	fifo_write_a: assert property (data_wr && (slot == cfm_pkg::CFM_SLOT_FIFO) |=>
		fifo_reg == $past(io_req.wdata))
		else $error("fifo threshold write lost");
	mem_num_wr_a: assert property (data_wr && (slot == cfm_pkg::CFM_SLOT_MNUM) |=>
		s_r.regs[cfm_pkg::CFM_SLOT_MNUM] == $past(io_req.wdata))
		else $error("memory numerator write lost");
	attr_reserved_a: assert property (data_wr && (slot == cfm_pkg::CFM_SLOT_ATTR) |=>
		(s_r.regs[cfm_pkg::CFM_SLOT_ATTR] == {5'h00, $past(io_req.wdata[2:0])}) ##1
		(attr_fifo_thresh == {1'b0, $past(io_req.wdata[2:0], 2)} + 4'h1))
		else $error("attribute threshold wrong");
	attr_range_a: assert property (1'b1 |=> (attr_fifo_thresh != 4'h0) &&
		(attr_fifo_thresh <= 4'h8))
		else $error("attribute threshold out of range");

	// display fifo arbitration, thresholds as they stood a cycle ago
	nowait_thr_a: assert property (1'b1 |=>
		host_nowait == ($past(disp_fifo_level) >
		({1'b0, $past(fifo_reg[3:0])} + 5'h04)))
		else $error("no-wait grant wrong");
	hold_thr_a: assert property (1'b1 |=>
		host_hold == ($past(disp_fifo_level) <
		({1'b0, $past(fifo_reg[7:4])} + 5'h03)))
		else $error("host hold wrong");

	// timing generator pulse, one per carrying write
	tg_pulse_a: assert property (data_wr && (slot == cfm_pkg::CFM_SLOT_MISC) &&
		io_req.wdata[cfm_pkg::CFM_MC_TG_RST] ##1 !data_wr |->
		misc_ctl.tg_reset ##1 !misc_ctl.tg_reset)
		else $error("timing reset pulse wrong");
	tg_quiet_a: assert property (!(io_req.wr && data_port &&
		(s_r.index == cfm_pkg::CFM_IDX_MISC) && io_req.wdata[cfm_pkg::CFM_MC_TG_RST]) |=>
		!misc_ctl.tg_reset)
		else $error("timing reset without write");

	// synthesizer programming words
	pix_set_a: assert property ($stable(pixel_clock_set_sel) && pixel_clock_set_sel &&
		!data_wr |=> pix_synth.div == ({3'h0, s_r.regs[cfm_pkg::CFM_SLOT_PIXB][7:1]} +
		10'h001) << ($past(pix_num_b[7]) ? 2 : 1))
		else $error("pixel set b divisor wrong");
	pixb_mult_a: assert property (pixel_clock_set_sel && !data_wr |=>
		pix_synth.mult == ({3'h0, $past(pix_num_b[6:0])} + 10'h001) <<
		(s_r.regs[cfm_pkg::CFM_SLOT_PIXB][0] ? 2 : 1))
		else $error("pixel set b multiplier wrong");
	pixa_mult_a: assert property (!pixel_clock_set_sel && !data_wr |=>
		pix_synth.mult == ({3'h0, $past(pix_num_a[6:0])} + 10'h001) <<
		(s_r.regs[cfm_pkg::CFM_SLOT_PIXA][0] ? 2 : 1))
		else $error("pixel set a multiplier wrong");
	pixa_div_a: assert property (!pixel_clock_set_sel && !data_wr |=>
		pix_synth.div == ({3'h0, s_r.regs[cfm_pkg::CFM_SLOT_PIXA][7:1]} + 10'h001) <<
		($past(pix_num_a[7]) ? 2 : 1))
		else $error("pixel set a divisor wrong");
	mem_mult_a: assert property (!data_wr ##1 !data_wr |=>
		mem_synth.mult == (({3'h0, s_r.regs[cfm_pkg::CFM_SLOT_MNUM][6:0]} + 10'h001) <<
		(s_r.regs[cfm_pkg::CFM_SLOT_MDP][0] ? 2 : 1)))
		else $error("memory multiplier wrong");
	mem_div_a: assert property (!data_wr |=>
		mem_synth.div == ({3'h0, s_r.regs[cfm_pkg::CFM_SLOT_MDP][7:1]} + 10'h001) <<
		(s_r.regs[cfm_pkg::CFM_SLOT_MNUM][7] ? 2 : 1))
		else $error("memory divisor wrong");

	// clock test decode
	obs_sel_a: assert property (s_r.regs[cfm_pkg::CFM_SLOT_CTST][1:0] == 2'h1 && !data_wr
		|=> clk_ctl.obs_sel == cfm_pkg::CFM_OBS_MEMCLK)
		else $error("observation select wrong");
	obs_pix_a: assert property (ct_reg[1] |=> clk_ctl.obs_sel == cfm_pkg::CFM_OBS_PIXCLK)
		else $error("observation pixel clock wrong");
	obs_other_a: assert property (ct_reg[1:0] == 2'h0 |=>
		clk_ctl.obs_sel == cfm_pkg::CFM_OBS_OTHER)
		else $error("observation default wrong");
	pix_src_a: assert property (1'b1 |=> clk_ctl.pix_src == $past(ct_reg[3:2]))
		else $error("pixel clock source wrong");
	tv_half_a: assert property (1'b1 |=> clk_ctl.tv_half == $past(ct_reg[4]))
		else $error("tv halving wrong");
	synth_off_a: assert property (1'b1 |=>
		{clk_ctl.osc_pd, clk_ctl.pix_pd, clk_ctl.mem_pd} == $past(ct_reg[7:5]))
		else $error("synthesizer power down wrong");

	// misc control decode
	dac_off_a: assert property (s_r.regs[cfm_pkg::CFM_SLOT_MISC][1] && !data_wr |=>
		misc_ctl.dac_pd && misc_ctl.refresh_stop)
		else $error("dac power down wrong");
	sense_off_a: assert property (1'b1 |=> misc_ctl.sense_pd == $past(mc_reg[0]))
		else $error("sense power down wrong");
	pal_off_a: assert property (1'b1 |=> misc_ctl.pal_pd == $past(mc_reg[3]))
		else $error("palette power down wrong");
	width_sel_a: assert property (1'b1 |=> misc_ctl.host_width == $past(mc_reg[5:4]))
		else $error("host width wrong");
	bus16_a: assert property (1'b1 |=> misc_ctl.bus16 ==
		($past(mode_16col) && $past(mc_reg[6])))
		else $error("16-bit access enable wrong");
	bypass_a: assert property (1'b1 |=> misc_ctl.pal_bypass == $past(mc_reg[7]))
		else $error("palette bypass wrong");

	// main scenarios
	rw_cov_c: cover property (data_wr ##1 data_rd ##1 io_rvalid);
	hold_cov_c: cover property (host_hold ##[1:20] host_nowait);
	tg_cov_c: cover property (misc_ctl.tg_reset);
	setb_cov_c: cover property (pixel_clock_set_sel ##1 !pixel_clock_set_sel);
	width_cov_c: cover property (misc_ctl.host_width == cfm_pkg::CFM_W32_16);

endmodule : cfm_regs
